// ==== pkg/ats_pkg.sv ====
// Constants, types and decode helpers for the trigger source selector
package ats_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low bits decoded)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_TRIG_SEL  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL      = 8'h04;
  localparam logic [23:0] ADDR_HI_ZERO   = 24'h00_0000;
  localparam logic [15:0] TRIG_SEL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_W        = 4;
  localparam int M0G1_SEL_LSB = 8;
  localparam int M1G0_SEL_LSB = 4;
  localparam int M0_START_BIT = 0;
  localparam int M0_MODE_LSB  = 1;
  localparam int M1_START_BIT = 8;
  localparam int M1_MODE_LSB  = 9;

  // ----------------------------------------------------------------
  // Operating modes and trigger codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SCAN4,
    MODE_SCAN2,
    MODE_RSVD
  } ats_mode_e;

  localparam logic [3:0] CODE_EXT  = 4'h0;
  localparam logic [3:0] CODE_TRGA = 4'h1;
  localparam logic [3:0] CODE_CH0  = 4'h2;
  localparam logic [3:0] CODE_DLYA = 4'h3;
  localparam logic [3:0] CODE_DLYB = 4'h4;
  localparam int         NUM_LINES = 5;

  // Codes 0101..1111 select no line at all
  function automatic logic ats_sel_line(input logic [3:0] code,
                                        input logic [4:0] lines);
    logic hit;
    hit = 1'b0;
    if (code <= CODE_DLYB) begin
      hit = lines[code[2:0]];
    end
    return hit;
  endfunction : ats_sel_line

endpackage : ats_pkg

// ==== pkg/ats_trig_if.sv ====
// Trigger request lines shared by the selector and its edge units
`timescale 1ns/1ns
interface ats_trig_if;
  // [0] ext pin, [1] timer A, [2] ch0 compare, [3] delay A, [4] delay B
  logic [4:0] lines;
  modport drive (output lines);
  modport sense (input  lines);
endinterface : ats_trig_if

// ==== src/ats_trig_edge.sv ====
// One trigger selector with rising edge detection
`timescale 1ns/1ns
module ats_trig_edge
  import ats_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  ats_trig_if.sense       trig,
  input  wire logic [3:0] sel,
  output logic            startReq
);

  logic cur;
  logic prev_q;

  assign cur      = ats_sel_line(sel, trig.lines);
  // A level held high starts only once
  assign startReq = cur & ~prev_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cur;
    end
  end

endmodule : ats_trig_edge

// ==== src/ats_top.sv ====
// Trigger source selector for two converter groups, AHB-Lite slave
// Contract
// - Bits 11..8 pick module 0 group 1 trigger
// - Bits 7..4 pick module 1 group 0 trigger
// - Code 0000 selects the external trigger pin
// - Code 0001 selects timer trigger A
// - Code 0010 selects timer channel 0 compare
// - Codes 0011/0100 select delayed requests A/B
// - Module 0 group 1 only in 2-channel scan
`timescale 1ns/1ns
module ats_top
  import ats_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        externalTriggerPin,
  input  wire logic        timerTriggerA,
  input  wire logic        timerCh0CompareTrigger,
  input  wire logic        timerDelayedRequestA,
  input  wire logic        timerDelayedRequestB,
  input  wire logic        mod0ConvDone,
  input  wire logic        mod1ConvDone,
  output logic             mod0StartBit,
  output logic             mod1StartBit
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] trigSel_q, trigSel_d;
  ats_mode_e   mode0_q, mode0_d;
  ats_mode_e   mode1_q, mode1_d;
  logic        start0_q, start0_d;
  logic        start1_q, start1_d;
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        hreadyout_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        addrOk;
  logic        addrHit;
  logic        rdTake;
  logic        wrSel;
  logic        wrCtrl;
  logic [31:0] rdVal;
  logic [31:0] ctrlVal;

  // Only whole-word transfers are issued, so hsize is not decoded
  assign addrOk  = hsel & htrans[1] & hready;
  assign addrHit = (haddr[31:8] == ADDR_HI_ZERO);
  assign rdTake  = addrOk & ~hwrite;
  assign wrPend_d = addrOk & hwrite & addrHit;
  assign wrAddr_d = addrOk ? haddr[7:0] : wrAddr_q;
  assign wrSel   = wrPend_q & (wrAddr_q == ADDR_TRIG_SEL);
  assign wrCtrl  = wrPend_q & (wrAddr_q == ADDR_CTRL);

  // Reads see the value after a write still in its data phase
  assign ctrlVal = {21'h00_0000, mode1_d, start1_d,
                    5'h00, mode0_d, start0_d};
  assign rdVal   = !addrHit                  ? 32'h0000_0000 :
                   (haddr[7:0] == ADDR_TRIG_SEL) ? {16'h0000, trigSel_d} :
                   (haddr[7:0] == ADDR_CTRL)     ? ctrlVal :
                                                   32'h0000_0000;
  assign hrdata_d = rdTake ? rdVal : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  ats_trig_if trigIf ();
  logic g1Req;
  logic m1Req;
  logic setHw0;
  logic setHw1;

  // Line index equals the select code for codes 0 to 4
  assign trigIf.lines = {timerDelayedRequestB, timerDelayedRequestA,
                         timerCh0CompareTrigger, timerTriggerA,
                         externalTriggerPin};

  ats_trig_edge uG1Edge (
    .clock    (clock),
    .rstn     (rstn),
    .trig     (trigIf.sense),
    .sel      (trigSel_q[M0G1_SEL_LSB +: SEL_W]),
    .startReq (g1Req)
  );

  ats_trig_edge uM1Edge (
    .clock    (clock),
    .rstn     (rstn),
    .trig     (trigIf.sense),
    .sel      (trigSel_q[M1G0_SEL_LSB +: SEL_W]),
    .startReq (m1Req)
  );

  // Group 1 of module 0 exists only in 2-channel scan
  assign setHw0 = g1Req & (mode0_q == MODE_SCAN2);
  assign setHw1 = m1Req & (mode1_q != MODE_RSVD);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign trigSel_d = wrSel ? hwdata[15:0] : trigSel_q;
  assign mode0_d   = wrCtrl ? ats_mode_e'(hwdata[M0_MODE_LSB +: 2])
                            : mode0_q;
  assign mode1_d   = wrCtrl ? ats_mode_e'(hwdata[M1_MODE_LSB +: 2])
                            : mode1_q;
  // A trigger in the same cycle as a clear still starts conversion
  assign start0_d  = setHw0 | (wrCtrl ? hwdata[M0_START_BIT]
                                      : start0_q & ~mod0ConvDone);
  assign start1_d  = setHw1 | (wrCtrl ? hwdata[M1_START_BIT]
                                      : start1_q & ~mod1ConvDone);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trigSel_q <= TRIG_SEL_RESET;
      mode0_q   <= MODE_SINGLE;
      mode1_q   <= MODE_SINGLE;
      start0_q  <= 1'b0;
      start1_q  <= 1'b0;
    end else begin
      trigSel_q <= trigSel_d;
      mode0_q   <= mode0_d;
      mode1_q   <= mode1_d;
      start0_q  <= start0_d;
      start1_q  <= start1_d;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPend_q    <= 1'b0;
      wrAddr_q    <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      wrPend_q    <= wrPend_d;
      wrAddr_q    <= wrAddr_d;
      hrdata_q    <= hrdata_d;
      hreadyout_q <= 1'b1;
    end
  end

  assign hrdata       = hrdata_q;
  assign hreadyout    = hreadyout_q;
  assign hresp        = 1'b0;
  assign mod0StartBit = start0_q;
  assign mod1StartBit = start1_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic [3:0] selG1;
  logic [3:0] selM1;
  logic       m1ModeOk;
  assign selG1    = trigSel_q[M0G1_SEL_LSB +: SEL_W];
  assign selM1    = trigSel_q[M1G0_SEL_LSB +: SEL_W];
  assign m1ModeOk = (mode1_q != MODE_RSVD);

  a_g1_ext_start: assert property (
    selG1 == CODE_EXT && $stable(selG1) && mode0_q == MODE_SCAN2 &&
    $rose(externalTriggerPin) |=> start0_q)
    else $error("ext pin edge did not start module 0");

  a_g1_mode_gate: assert property (
    mode0_q != MODE_SCAN2 && !wrCtrl && !start0_q |=> !start0_q)
    else $error("module 0 started outside 2-channel scan");

  a_m1_trga_start: assert property (
    selM1 == CODE_TRGA && $stable(selM1) && m1ModeOk &&
    $rose(timerTriggerA) |=> start1_q)
    else $error("timer A edge did not start module 1");

  a_m1_ch0_start: assert property (
    selM1 == CODE_CH0 && $stable(selM1) && m1ModeOk &&
    $rose(timerCh0CompareTrigger) |=> start1_q)
    else $error("ch0 compare edge did not start module 1");

  a_m1_dly_start: assert property (
    m1ModeOk && $stable(selM1) &&
    ((selM1 == CODE_DLYA && $rose(timerDelayedRequestA)) ||
     (selM1 == CODE_DLYB && $rose(timerDelayedRequestB)))
    |=> start1_q)
    else $error("delayed request edge did not start module 1");

  a_m1_field_pos: assert property (
    wrSel |=> selM1 == $past(hwdata[7:4]) && selG1 == $past(hwdata[11:8]))
    else $error("select fields not at their bit positions");

  a_m1_unselected: assert property (
    selM1 == CODE_EXT && !externalTriggerPin && !wrCtrl && !start1_q
    ##1 !externalTriggerPin && !wrCtrl |-> !start1_q)
    else $error("unselected line started module 1");

  a_m1_level_once: assert property (
    selM1 == CODE_EXT && $stable(selM1) && externalTriggerPin &&
    $past(externalTriggerPin) |-> !m1Req)
    else $error("held trigger level gave a second request");

  c_g1_start:  cover property (setHw0);
  c_m1_start:  cover property (setHw1);
  c_set_clear: cover property (setHw1 && mod1ConvDone);
  c_rd_ctrl:   cover property (rdTake && haddr[7:0] == ADDR_CTRL);

endmodule : ats_top

// ==== verification/ats_trig_model.sv ====
// Far-side model: timer request lines and external trigger pin
`timescale 1ns/1ns
module ats_trig_model
  import ats_pkg::*;
#(
  parameter int LAG = 0
)
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [4:0] fireMask,
  output logic      [4:0] trigLines
);
  // ----------------------------------------------------------------
  // Request lines, delayed by LAG+1 cycles to model a slow timer
  // ----------------------------------------------------------------
  logic [4:0] stage_q [0:3];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        stage_q[i] <= 5'h00;
      end
    end else begin
      stage_q[0] <= fireMask;
      for (int i = 1; i < 4; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // Lines follow fireMask, so a fresh rise needs fireMask to fall back low between requests
  assign trigLines = stage_q[LAG];
endmodule : ats_trig_model

// ==== verification/ats_top_tb.sv ====
// Self-checking bench for the trigger source selector
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin \
  numErrors++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module ats_top_tb
  import ats_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clock, rstn, hsel, hwrite, hreadyout, hresp, done0, done1;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  fireMask, trigLines;
  logic        start0, start1;
  int          numErrors, nTests;
  localparam logic [31:0] SEL_A = {ADDR_HI_ZERO, ADDR_TRIG_SEL};
  localparam logic [31:0] CTL_A = {ADDR_HI_ZERO, ADDR_CTRL};

  ats_trig_model #(.LAG(1)) partner (.clock(clock), .rstn(rstn),
    .fireMask(fireMask), .trigLines(trigLines));

  ats_top dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .externalTriggerPin(trigLines[0]),
    .timerTriggerA(trigLines[1]), .timerCh0CompareTrigger(trigLines[2]),
    .timerDelayedRequestA(trigLines[3]),
    .timerDelayedRequestB(trigLines[4]), .mod0ConvDone(done0),
    .mod1ConvDone(done1), .mod0StartBit(start0), .mod1StartBit(start1));

  // ----------------------------------------------------------------
  // Bus and trigger tasks
  // ----------------------------------------------------------------
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : giveVerdict

  // Bounded wait: a slave that never answers ends the run
  task automatic waitRdy;
    int i;
    i = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 20) begin
        numErrors++;
        giveVerdict();
      end
      @(posedge clock);
    end
  endtask : waitRdy

  task automatic busOp(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    waitRdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : busOp

  task automatic wrReg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    busOp(1'b1, a, d, x);
  endtask : wrReg

  task automatic rdChk(input string nm, input logic [31:0] a,
                       input logic [31:0] ex);
    logic [31:0] x;
    busOp(1'b0, a, 32'h0000_0000, x);
    `CHK(nm, ex, x)
  endtask : rdChk

  task automatic pulse(input int idx);
    fireMask <= 5'h01 << idx;
    @(posedge clock);
    fireMask <= 5'h00;
    repeat (3) @(posedge clock);
  endtask : pulse

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset;
    rdChk("selReset", SEL_A, 32'h0000_0000);
    rdChk("ctrlReset", CTL_A, 32'h0000_0000);
    rdChk("unmapped", 32'h0000_0008, 32'h0000_0000);
    $display("test reset done");
  endtask : testReset

  task automatic testMod1Codes;
    for (int c = 0; c < 5; c++) begin
      wrReg(CTL_A, 32'h0000_0000);
      wrReg(SEL_A, 32'(c) << 4);
      rdChk("selBack", SEL_A, 32'(c) << 4);
      pulse((c + 1) % 5);
      `CHK("otherLine", 1'b0, start1)
      pulse(c);
      `CHK("codeLine", 1'b1, start1)
      done1 <= 1'b1;
      @(posedge clock);
      done1 <= 1'b0;
      @(posedge clock);
      `CHK("doneClear", 1'b0, start1)
    end
    $display("test module 1 codes done");
  endtask : testMod1Codes

  task automatic testMod0Group1;
    wrReg(CTL_A, 32'h0000_0000);
    wrReg(SEL_A, 32'h0000_0310);
    pulse(3);
    `CHK("singleMode", 1'b0, start0)
    wrReg(CTL_A, 32'h0000_0004);
    pulse(1);
    `CHK("group0Line", 1'b0, start0)
    pulse(3);
    `CHK("scan2Start", 1'b1, start0)
    // Module 1 selects timer A, so the earlier line 1 pulse started it
    `CHK("mod1Start", 1'b1, start1)
    rdChk("ctrlBack", CTL_A, 32'h0000_0105);
    wrReg(CTL_A, 32'h0000_0004);
    // The write lands at the end edge of its data phase
    @(posedge clock);
    `CHK("swClear", 1'b0, start0)
    wrReg(SEL_A, 32'h0000_0020);
    pulse(0);
    `CHK("g1ExtStart", 1'b1, start0)
    `CHK("m1IgnoresExt", 1'b0, start1)
    done0 <= 1'b1;
    @(posedge clock);
    done0 <= 1'b0;
    @(posedge clock);
    `CHK("done0Clear", 1'b0, start0)
    $display("test module 0 group 1 done");
  endtask : testMod0Group1

  task automatic testMod1Modes;
    wrReg(CTL_A, 32'h0000_0604);
    pulse(2);
    `CHK("rsvdMode", 1'b0, start1)
    wrReg(CTL_A, 32'h0000_0200);
    pulse(2);
    `CHK("scan4Mode", 1'b1, start1)
    wrReg(CTL_A, 32'h0000_0000);
    wrReg(SEL_A, 32'h0000_0000);
    // Hold the pin high across a done clear: no second start
    fireMask <= 5'h01;
    repeat (4) @(posedge clock);
    done1 <= 1'b1;
    @(posedge clock);
    done1 <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK("levelOnce", 1'b0, start1)
    fireMask <= 5'h00;
    repeat (3) @(posedge clock);
    $display("test module 1 modes done");
  endtask : testMod1Modes

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {done0, done1, fireMask, numErrors, nTests} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    testReset();
    testMod1Codes();
    testMod0Group1();
    testMod1Modes();
    giveVerdict();
  end
endmodule : ats_top_tb
